/* File: irc_pkg.sv */
package irc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_GLOBAL_STATE = 8'h08;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_SOURCE_SIZE = 8'h10;
    localparam logic [7:0] OFS_TARGET_SIZE = 8'h14;
    localparam logic [7:0] OFS_HORIZ_RATIO = 8'h18;
    localparam logic [7:0] OFS_VERT_RATIO = 8'h1C;
    localparam logic [7:0] OFS_HORIZ_REMAINDER = 8'h20;
    localparam logic [7:0] OFS_VERT_REMAINDER = 8'h24;
    localparam logic [7:0] OFS_FINE_SCALE_CONFIG = 8'h40;
    localparam logic [7:0] OFS_LINE_MEMORY_BASE = 8'h5C;
    localparam logic [7:0] OFS_COLOR_CONVERT_CONFIG = 8'h80;
    localparam logic [7:0] OFS_TARGET_BASE_FIRST = 8'h84;
    localparam logic [7:0] OFS_TARGET_BASE_SECOND = 8'h88;

    // field positions
    localparam int BIT_CONT_RUN = 4;
    localparam int BIT_HORIZ_GO = 0;
    localparam int BIT_VERT_GO = 1;
    localparam int BIT_WRITER_GO = 2;
    localparam int BIT_HORIZ_RST = 16;
    localparam int BIT_VERT_RST = 17;
    localparam int BIT_WRITER_RST = 18;
    localparam int BIT_STA_HBUSY = 0;
    localparam int BIT_STA_VBUSY = 1;
    localparam int BIT_STA_WBUSY = 2;
    localparam int BIT_STA_OVRUN = 3;
    localparam int BIT_STA_LINE_MEMORY_FULL_FLAG = 4;
    localparam int BIT_STA_STALL = 5;
    localparam int BIT_INT_HDONE = 0;
    localparam int BIT_INT_VDONE = 1;
    localparam int BIT_INT_WDONE = 2;
    localparam int BIT_VSKIP = 0;
    localparam int BIT_AVG = 1;
    localparam int BIT_HIRQ = 4;
    localparam int BIT_VIRQ = 5;
    localparam int LSB_PRESHRINK = 8;
    localparam int LSB_LMDEPTH = 16;
    localparam int BIT_OUT_MODE = 0;
    localparam int BIT_CONV_IRQ = 15;

    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [9:0] LM_DEPTH_MIN = 10'h004;

    typedef enum logic [1:0] {
        IRC_SHRINK_NONE = 2'b00,
        IRC_SHRINK_HALF = 2'b01,
        IRC_SHRINK_QUARTER = 2'b10,
        IRC_SHRINK_EIGHTH = 2'b11
    } irc_shrink_t;

    typedef enum logic [1:0] {
        IRC_ST_IDLE = 2'b00,
        IRC_ST_RUN = 2'b01,
        IRC_ST_HELD = 2'b10
    } irc_stage_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } irc_bus_req_t;

    // events reported by the pixel datapath
    typedef struct packed {
        logic horiz_done;
        logic vert_done;
        logic writer_done;
        logic pixel_req;
        logic pixel_ack;
        logic line_memory_full;
        logic frame_start;
        logic line_memory_empty;
    } irc_events_t;

    typedef struct packed {
        logic [10:0] source_width;
        logic [10:0] source_height;
        logic [10:0] target_width;
        logic [10:0] target_height;
        logic [31:0] horiz_ratio;
        logic [31:0] vert_ratio;
        logic [15:0] horiz_remainder;
        logic [15:0] vert_remainder;
        logic vert_line_skip_en;
        logic averaging_en;
        irc_shrink_t pre_shrink_factor;
        logic [9:0] line_memory_depth;
        logic [31:0] line_memory_base;
        logic yuv_out;
        logic [31:0] target_base;
        logic continuous;
    } irc_config_t;
endpackage

/* File: irc_top.sv */
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - three busy bits: horizontal, vertical, writer
// - flag unacknowledged pixel request, memory full
// - flag new frame with line memory nonempty
// - horizontal done sets sticky bit, read clears
// - vertical done sets sticky bit, read clears
// - writer done sets sticky bit, read clears
// - source width low, height high half
// - target width low, height high half
// - line skip bit drops lines vertically
// - averaging bit enables 1/n averaging
// - stage irqs gated by their enables
// - two-bit horizontal coarse shrink factor
// - line memory depth field, minimum four
// - line memory base address register
// - output mode bit, conversion irq enable
// - alternate two target bases per frame
// - go bits start the three stages
// - writer reset bit holds writer stopped
module irc_top (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire irc_pkg::irc_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    input wire irc_pkg::irc_events_t events_i,
    output irc_pkg::irc_config_t config_o,
    output logic horiz_run_o,
    output logic vert_run_o,
    output logic writer_run_o,
    output logic horiz_irq_o,
    output logic vert_irq_o,
    output logic convert_irq_o
);
    import irc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic cont_q;
    logic [2:0] go_q;
    logic [2:0] hold_q;
    logic [31:0] src_q, tgt_q, hrat_q, vrat_q, base_q, tb1_q, tb2_q;
    logic [15:0] hres_q, vres_q;
    logic [31:0] fcfg_q;
    logic [31:0] ccfg_q;
    logic [2:0] done_q;
    logic [2:0] err_q;
    logic tsel_q;
    logic [31:0] rdata_q;
    irc_stage_t st_q [3];

    wire wr = bus_i.wr;
    wire rd = bus_i.rd;
    wire [7:0] a = bus_i.addr;
    wire [31:0] wd = bus_i.wdata;

    function automatic logic hit(input logic [7:0] ofs, input logic [7:0] adr);
        hit = (adr == ofs);
    endfunction

    wire int_rd = rd && hit(OFS_INTERRUPT_FLAGS, a);
    wire [2:0] stage_done = {events_i.writer_done, events_i.vert_done,
                             events_i.horiz_done};

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cont_q <= 1'b0;
            go_q <= 3'h0;
            hold_q <= 3'h0;
            src_q <= RESET_VALUE;
            tgt_q <= RESET_VALUE;
            hrat_q <= RESET_VALUE;
            vrat_q <= RESET_VALUE;
            hres_q <= 16'h0000;
            vres_q <= 16'h0000;
            fcfg_q <= RESET_VALUE;
            base_q <= RESET_VALUE;
            ccfg_q <= RESET_VALUE;
            tb1_q <= RESET_VALUE;
            tb2_q <= RESET_VALUE;
        end else if (wr) begin
            if (hit(OFS_GLOBAL_CONFIG, a)) cont_q <= wd[BIT_CONT_RUN];
            if (hit(OFS_CONTROL, a)) begin
                go_q <= {wd[BIT_WRITER_GO], wd[BIT_VERT_GO], wd[BIT_HORIZ_GO]};
                hold_q <= {wd[BIT_WRITER_RST], wd[BIT_VERT_RST], wd[BIT_HORIZ_RST]};
            end
            if (hit(OFS_SOURCE_SIZE, a)) src_q <= wd;
            if (hit(OFS_TARGET_SIZE, a)) tgt_q <= wd;
            if (hit(OFS_HORIZ_RATIO, a)) hrat_q <= wd;
            if (hit(OFS_VERT_RATIO, a)) vrat_q <= wd;
            if (hit(OFS_HORIZ_REMAINDER, a)) hres_q <= wd[15:0];
            if (hit(OFS_VERT_REMAINDER, a)) vres_q <= wd[15:0];
            if (hit(OFS_FINE_SCALE_CONFIG, a)) fcfg_q <= wd & 32'h03FF_0333;
            if (hit(OFS_LINE_MEMORY_BASE, a)) base_q <= wd;
            if (hit(OFS_COLOR_CONVERT_CONFIG, a)) ccfg_q <= wd & 32'h0000_8001;
            if (hit(OFS_TARGET_BASE_FIRST, a)) tb1_q <= {wd[31:1], 1'b0};
            if (hit(OFS_TARGET_BASE_SECOND, a)) tb2_q <= {wd[31:1], 1'b0};
        end else begin
            // go is a start strobe, cleared in the first cycle without a bus write
            go_q <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage machines: horizontal, vertical, writer
    for (genvar i = 0; i < 3; i++) begin : g_stage
        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                st_q[i] <= IRC_ST_IDLE;
            end else if (hold_q[i]) begin
                st_q[i] <= IRC_ST_HELD;
            end else begin
                unique case (st_q[i])
                    IRC_ST_IDLE: begin
                        if (go_q[i]) st_q[i] <= IRC_ST_RUN;
                    end
                    IRC_ST_RUN: begin
                        // continuous run only stops through the hold bits
                        if (stage_done[i] && !cont_q) st_q[i] <= IRC_ST_IDLE;
                    end
                    IRC_ST_HELD: begin
                        // a go written together with the hold release still starts
                        st_q[i] <= go_q[i] ? IRC_ST_RUN : IRC_ST_IDLE;
                    end
                    default: begin
                        st_q[i] <= IRC_ST_IDLE;
                    end
                endcase
            end
        end
    end

    wire h_busy = (st_q[0] == IRC_ST_RUN);
    wire v_busy = (st_q[1] == IRC_ST_RUN);
    wire w_busy = (st_q[2] == IRC_ST_RUN);

    ////////////////////////////////////////////////////////////////////
    // sticky done bits: set wins over the clearing read
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            done_q <= 3'h0;
        end else begin
            done_q[0] <= events_i.horiz_done | (done_q[0] & ~int_rd);
            done_q[1] <= events_i.vert_done | (done_q[1] & ~int_rd);
            done_q[2] <= events_i.writer_done | (done_q[2] & ~int_rd);
        end
    end

    // error flags: no clear exists besides reset, they stay until then
    wire ovrun_ev = events_i.pixel_req & ~events_i.pixel_ack;
    wire stall_ev = events_i.frame_start & ~events_i.line_memory_empty;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            err_q <= 3'h0;
        end else begin
            err_q[0] <= err_q[0] | ovrun_ev;
            err_q[1] <= err_q[1] | events_i.line_memory_full;
            err_q[2] <= err_q[2] | stall_ev;
        end
    end

    // target base flips after each finished image
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || hold_q[2]) begin
            tsel_q <= 1'b0;
        end else if (events_i.writer_done) begin
            tsel_q <= ~tsel_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path
    wire [31:0] sta_w = {26'h0, err_q[2], err_q[1], err_q[0], w_busy, v_busy, h_busy};
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (a)
            OFS_GLOBAL_CONFIG: rmux = {27'h0, cont_q, 4'h0};
            OFS_CONTROL: rmux = {13'h0, hold_q, 16'h0};
            OFS_GLOBAL_STATE: rmux = sta_w;
            OFS_INTERRUPT_FLAGS: rmux = {29'h0, done_q};
            OFS_SOURCE_SIZE: rmux = src_q;
            OFS_TARGET_SIZE: rmux = tgt_q;
            OFS_HORIZ_RATIO: rmux = hrat_q;
            OFS_VERT_RATIO: rmux = vrat_q;
            OFS_HORIZ_REMAINDER: rmux = {16'h0, hres_q};
            OFS_VERT_REMAINDER: rmux = {16'h0, vres_q};
            OFS_FINE_SCALE_CONFIG: rmux = fcfg_q;
            OFS_LINE_MEMORY_BASE: rmux = base_q;
            OFS_COLOR_CONVERT_CONFIG: rmux = ccfg_q;
            OFS_TARGET_BASE_FIRST: rmux = tb1_q;
            OFS_TARGET_BASE_SECOND: rmux = tb2_q;
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            rdata_q <= rmux;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // configuration towards the datapath
    wire [9:0] depth_raw = fcfg_q[LSB_LMDEPTH +: 10];
    assign config_o.source_width = src_q[10:0];
    assign config_o.source_height = src_q[26:16];
    assign config_o.target_width = tgt_q[10:0];
    assign config_o.target_height = tgt_q[26:16];
    assign config_o.horiz_ratio = hrat_q;
    assign config_o.vert_ratio = vrat_q;
    assign config_o.horiz_remainder = hres_q;
    assign config_o.vert_remainder = vres_q;
    assign config_o.vert_line_skip_en = fcfg_q[BIT_VSKIP];
    assign config_o.averaging_en = fcfg_q[BIT_AVG];
    assign config_o.pre_shrink_factor = irc_shrink_t'(fcfg_q[LSB_PRESHRINK +: 2]);
    // depths below the minimum are raised to it rather than rejected
    assign config_o.line_memory_depth = (depth_raw < LM_DEPTH_MIN) ? LM_DEPTH_MIN
                                                                  : depth_raw;
    assign config_o.line_memory_base = base_q;
    assign config_o.yuv_out = ccfg_q[BIT_OUT_MODE];
    assign config_o.target_base = tsel_q ? tb2_q : tb1_q;
    assign config_o.continuous = cont_q;

    assign horiz_run_o = h_busy;
    assign vert_run_o = v_busy;
    assign writer_run_o = w_busy;
    assign horiz_irq_o = events_i.horiz_done & fcfg_q[BIT_HIRQ];
    assign vert_irq_o = events_i.vert_done & fcfg_q[BIT_VIRQ];
    assign convert_irq_o = events_i.writer_done & ccfg_q[BIT_CONV_IRQ];
endmodule
`default_nettype wire

/* File: irc_dp_model.sv */
`timescale 1ns/10ps
`default_nettype none
// datapath stand-in: replays commanded event patterns one cycle late
module irc_dp_model (
    input wire logic sys_clk_i,
    input wire irc_pkg::irc_events_t cmd_i,
    output irc_pkg::irc_events_t events_o
);
    import irc_pkg::*;
    // registered so events never change on the bench's own drive step
    always_ff @(posedge sys_clk_i) begin
        events_o <= cmd_i;
    end
endmodule
`default_nettype wire

/* File: irc_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module irc_top_sva (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire irc_pkg::irc_bus_req_t bus_i,
    input wire logic [31:0] rdata_o,
    input wire irc_pkg::irc_events_t events_i,
    input wire irc_pkg::irc_config_t config_o,
    input wire logic horiz_run_o,
    input wire logic vert_run_o,
    input wire logic writer_run_o,
    input wire logic horiz_irq_o,
    input wire logic vert_irq_o,
    input wire logic convert_irq_o
);
    import irc_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire rd_sta = bus_i.rd && bus_i.addr == OFS_GLOBAL_STATE;
    wire rd_int = bus_i.rd && bus_i.addr == OFS_INTERRUPT_FLAGS;
    wire wr_con = bus_i.wr && bus_i.addr == OFS_CONTROL;
    wire any_done = events_i.horiz_done || events_i.vert_done || events_i.writer_done;
    ////////////////////////////////////////////////////////////////////////
    hirq_gate_a: assert property (horiz_irq_o |-> events_i.horiz_done)
        else $error("horizontal irq without done");
    virq_gate_a: assert property (vert_irq_o |-> events_i.vert_done)
        else $error("vertical irq without done");
    cirq_gate_a: assert property (convert_irq_o |-> events_i.writer_done)
        else $error("convert irq without done");
    busy_report_a: assert property (rd_sta |=> rdata_o[2:0] ==
        {$past(writer_run_o), $past(vert_run_o), $past(horiz_run_o)})
        else $error("busy bits wrong");
    flag_clear_a: assert property ((rd_int && !any_done) ##1 rd_int |=> rdata_o[2:0] == 3'h0)
        else $error("flags not cleared by read");
    hdone_sticky_a: assert property ((events_i.horiz_done && !rd_int) ##1 rd_int |=> rdata_o[0])
        else $error("horizontal done lost");
    wdone_sticky_a: assert property ((events_i.writer_done && !rd_int) ##1 rd_int |=> rdata_o[2])
        else $error("writer done lost");
    overrun_flag_a: assert property ((events_i.pixel_req && !events_i.pixel_ack) ##1 rd_sta
        |=> rdata_o[BIT_STA_OVRUN]) else $error("overrun not flagged");
    stall_flag_a: assert property ((events_i.frame_start && !events_i.line_memory_empty)
        ##1 rd_sta |=> rdata_o[BIT_STA_STALL]) else $error("stall not flagged");
    size_split_a: assert property (bus_i.wr && bus_i.addr == OFS_SOURCE_SIZE |=>
        config_o.source_width == $past(bus_i.wdata[10:0])
        && config_o.source_height == $past(bus_i.wdata[26:16])) else $error("size split wrong");
    writer_go_a: assert property ((wr_con && bus_i.wdata[2] && !bus_i.wdata[18])
        ##1 !events_i.writer_done |=> writer_run_o) else $error("writer did not start");
    writer_hold_a: assert property (wr_con && bus_i.wdata[18] |=> ##1 !writer_run_o [*2])
        else $error("writer runs while held");
    fine_cfg_a: assert property (bus_i.wr && bus_i.addr == OFS_FINE_SCALE_CONFIG |=>
        config_o.pre_shrink_factor == $past(bus_i.wdata[9:8]) && config_o.averaging_en
        == $past(bus_i.wdata[1]) && config_o.vert_line_skip_en == $past(bus_i.wdata[0]))
        else $error("fine config fields wrong");
endmodule
bind irc_top irc_top_sva i_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .events_i(events_i), .config_o(config_o), .horiz_run_o(horiz_run_o),
    .vert_run_o(vert_run_o), .writer_run_o(writer_run_o), .horiz_irq_o(horiz_irq_o),
    .vert_irq_o(vert_irq_o), .convert_irq_o(convert_irq_o));
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import irc_pkg::*;
    logic sys_clk_i = 0;
    logic reset_i = 1;
    irc_bus_req_t bus = '0;
    // event bits: h, v, w done, req, ack, full, frame, empty
    irc_events_t cmd = 8'h01;
    irc_events_t ev;
    irc_config_t cfg;
    logic [31:0] rdata, lfsr = 32'h0000_003C, v;
    logic hrun, vrun, wrun, hirq, virq, cirq, rd_q = 0, en_q = 0;
    int bad_count = 0, n_compared = 0, cyc = 0;
    logic [31:0] expq[$], vals[11];
    logic [7:0] ofs[11] = '{OFS_SOURCE_SIZE, OFS_TARGET_SIZE, OFS_HORIZ_RATIO, OFS_VERT_RATIO,
        OFS_HORIZ_REMAINDER, OFS_VERT_REMAINDER, OFS_FINE_SCALE_CONFIG, OFS_LINE_MEMORY_BASE,
        OFS_COLOR_CONVERT_CONFIG, OFS_TARGET_BASE_FIRST, OFS_TARGET_BASE_SECOND};
    // even targets, residuals under 2047, writable fields only
    logic [31:0] wm[11] = '{32'h07FF07FF, 32'h07FE07FE, '1, '1, 32'h7FE, 32'h7FE, 32'h03FF0333,
        '1, 32'h00008001, 32'hFFFFFFFE, 32'hFFFFFFFE};
    irc_dp_model i_dp (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .events_o(ev));
    irc_top i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
        .events_i(ev), .config_o(cfg), .horiz_run_o(hrun), .vert_run_o(vrun),
        .writer_run_o(wrun), .horiz_irq_o(hirq), .vert_irq_o(virq), .convert_irq_o(cirq));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus.wr <= 1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge sys_clk_i);
        bus.wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        bus.rd <= 1;
        bus.addr <= a;
        expq.push_back(e);
        @(posedge sys_clk_i);
        bus.rd <= 0;
    endtask
    // back-to-back reads: strobe held high over two edges
    task automatic rd2(input logic [7:0] a, input logic [31:0] e1, input logic [31:0] e2);
        @(posedge sys_clk_i);
        bus.rd <= 1;
        bus.addr <= a;
        expq.push_back(e1);
        expq.push_back(e2);
        repeat (2) @(posedge sys_clk_i);
        bus.rd <= 0;
    endtask
    task automatic pulse(input irc_events_t p);
        @(posedge sys_clk_i);
        cmd <= p;
        @(posedge sys_clk_i);
        cmd <= 8'h01;
    endtask
    task automatic complete_run();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // read data lands one cycle after the strobe; sample mid-cycle
    always @(posedge sys_clk_i) begin
        rd_q <= bus.rd;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    always @(negedge sys_clk_i) begin
        if (rd_q) chk("rdata", expq.pop_front(), rdata);
        if (ev.horiz_done) chk("horiz irq", en_q, hirq);
        if (ev.vert_done) chk("vert irq", en_q, virq);
        if (ev.writer_done) chk("convert irq", en_q, cirq);
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 0;
        rd(OFS_GLOBAL_STATE, 0);
        rd(OFS_INTERRUPT_FLAGS, 0);
        chk("depth floor", 4, cfg.line_memory_depth);
        // whole configuration goes in before any stage starts
        for (int i = 0; i < 11; i++) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr & wm[i];
            if (ofs[i] == OFS_FINE_SCALE_CONFIG) v[18] = 1'b1;
            vals[i] = v;
            wr(ofs[i], v);
            rd(ofs[i], v);
        end
        chk("target width", vals[1][10:0], cfg.target_width);
        chk("target height", vals[1][26:16], cfg.target_height);
        chk("output mode", vals[8][0], cfg.yuv_out);
        chk("line base", vals[7], cfg.line_memory_base);
        chk("horiz ratio", vals[2], cfg.horiz_ratio);
        chk("vert ratio", vals[3], cfg.vert_ratio);
        chk("horiz rem", vals[4], cfg.horiz_remainder);
        chk("vert rem", vals[5], cfg.vert_remainder);
        chk("line depth", vals[6][25:16], cfg.line_memory_depth);
        wr(8'h30, '1);
        rd(8'h30, 0);
        wr(OFS_GLOBAL_STATE, '1);
        rd(OFS_GLOBAL_STATE, 0);
        for (int k = 0; k < 2; k++) begin
            en_q = k[0];
            wr(OFS_FINE_SCALE_CONFIG, k[0] ? 32'h0004_0030 : 32'h0004_0000);
            wr(OFS_COLOR_CONVERT_CONFIG, k[0] ? 32'h8000 : 32'h0);
            pulse(8'hE1);
            rd(OFS_INTERRUPT_FLAGS, 32'h7);
            rd(OFS_INTERRUPT_FLAGS, 32'h0);
        end
        chk("base first", vals[9], cfg.target_base);
        pulse(8'h21);
        repeat (2) @(negedge sys_clk_i);
        chk("base second", vals[10], cfg.target_base);
        rd(OFS_INTERRUPT_FLAGS, 32'h4);
        wr(OFS_CONTROL, 32'h4);
        repeat (2) @(negedge sys_clk_i);
        chk("writer run", 1, wrun);
        rd(OFS_GLOBAL_STATE, 32'h4);
        wr(OFS_CONTROL, 32'h0004_0000);
        repeat (2) @(negedge sys_clk_i);
        chk("writer held", 0, wrun);
        rd(OFS_CONTROL, 32'h0004_0000);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, 32'h3);
        repeat (2) @(negedge sys_clk_i);
        chk("resize run", 3, {vrun, hrun});
        pulse(8'hC1);
        repeat (3) @(negedge sys_clk_i);
        chk("resize idle", 0, {vrun, hrun});
        rd(OFS_INTERRUPT_FLAGS, 32'h3);
        // continuous run: done pulses must not stop the stages
        wr(OFS_GLOBAL_CONFIG, 32'h10);
        rd(OFS_GLOBAL_CONFIG, 32'h10);
        wr(OFS_CONTROL, 32'h3);
        pulse(8'hC1);
        repeat (3) @(negedge sys_clk_i);
        chk("continuous", 3, {vrun, hrun});
        wr(OFS_CONTROL, 32'h0003_0000);
        repeat (2) @(negedge sys_clk_i);
        chk("resize held", 0, {vrun, hrun});
        rd2(OFS_INTERRUPT_FLAGS, 32'h3, 32'h0);
        // acknowledged request is no overrun; full alone flags
        pulse(8'h1D);
        rd(OFS_GLOBAL_STATE, 32'h10);
        pulse(8'h03);
        pulse(8'h12);
        rd(OFS_GLOBAL_STATE, 32'h38);
        repeat (3) @(posedge sys_clk_i);
        complete_run();
    end
endmodule
`default_nettype wire
